// file: design/smi_entry_pkg.sv
// constants and types for the management interrupt entry block
`default_nettype none
package smi_entry_pkg;
    localparam int        IRQ_W_DEF    = 8;
    localparam logic      PIN_IDLE     = 1'b1;
    localparam logic      PEND_RST     = 1'b0;
    localparam logic      ACTIVE_N_RST = 1'b1;
    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_ENTRY,
        ST_IN_MODE
    } mode_state_e;
endpackage
`default_nettype wire

// file: design/fall_edge_latch.sv
// falling-edge capture of an active-low request pin into a sticky flag
`timescale 1ns/100ps
`default_nettype none
module fall_edge_latch
    import smi_entry_pkg::*;
(
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pin and flag control
    input  wire logic req_n,
    input  wire logic clear,
    output logic      pending,
    output logic      fall
);
    logic req_n_q;
    logic next_req_n_q;
    logic next_pending;

    // edge detect; set beats a same-cycle clear so no edge is lost
    always_comb begin
        fall         = req_n_q & ~req_n;
        next_req_n_q = req_n;
        next_pending = fall | (pending & ~clear);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            req_n_q <= PIN_IDLE;
            pending <= PEND_RST;
        end else begin
            req_n_q <= next_req_n_q;
            pending <= next_pending;
        end
    end
endmodule
`default_nettype wire

// file: design/system_mgmt_irq_entry.sv
// management interrupt recognition, priority and mode tracking
`timescale 1ns/100ps
`default_nettype none
module system_mgmt_irq_entry
    import smi_entry_pkg::*;
#(
    parameter int IRQ_W = IRQ_W_DEF
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    // external request pins
    input  wire logic             sys_mgmt_req_n,
    input  wire logic [IRQ_W-1:0] ext_irq_req,
    // core sequencing
    input  wire logic             instr_boundary,
    input  wire logic             rep_iter_boundary,
    input  wire logic             bus_locked,
    input  wire logic             entry_done,
    input  wire logic             mode_resume_instr,
    // outputs
    output logic                  sys_mgmt_take,
    output logic [IRQ_W-1:0]      ext_irq_take,
    output logic                  sys_mgmt_mode,
    output logic                  sys_mgmt_active_n,
    output logic                  sys_mgmt_pending
);
    mode_state_e      state;
    mode_state_e      next_state;
    logic             pend;
    logic             fall;
    logic             recog;
    logic             take;
    logic             next_take;
    logic [IRQ_W-1:0] next_irq_take;
    logic             next_mode;
    logic             next_active_n;
    logic [IRQ_W-1:0] low_first;
    logic             next_sys_mgmt_pending;

    // pending flag cleared in the cycle entry starts
    fall_edge_latch u_latch (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .req_n   (sys_mgmt_req_n),
        .clear   (take),
        .pending (pend),
        .fall    (fall)
    );

    // lowest index wins among ordinary external requests
    assign low_first = ext_irq_req & (~ext_irq_req + {{(IRQ_W-1){1'b0}}, 1'b1});

    // recognition point: whole instruction or string step done, bus not locked
    always_comb begin
        recog = (instr_boundary | rep_iter_boundary) & ~bus_locked;
        take  = recog & pend & (state == ST_NORMAL);
    end

    // mode sequencing
    always_comb begin
        next_state    = state;
        next_take     = take;
        next_irq_take = '0;
        if (recog & ~take & (state == ST_NORMAL)) begin
            next_irq_take = low_first;
        end
        case (state)
            ST_NORMAL: begin
                if (take) begin
                    next_state = ST_ENTRY;
                end
            end
            ST_ENTRY: begin
                if (entry_done) begin
                    next_state = ST_IN_MODE;
                end
            end
            ST_IN_MODE: begin
                // a latched second request waits for resume
                if (mode_resume_instr) begin
                    next_state = ST_NORMAL;
                end
            end
            default: next_state = ST_NORMAL;
        endcase
        next_mode     = (next_state != ST_NORMAL);
        next_active_n = ~next_mode;
        // same next value as the latch, so the visible flag never lags it
        next_sys_mgmt_pending = fall | (pend & ~take);
    end

    // every top-level output leaves from a flop, none through logic
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state             <= ST_NORMAL;
            sys_mgmt_take     <= 1'b0;
            ext_irq_take      <= '0;
            sys_mgmt_mode     <= 1'b0;
            sys_mgmt_active_n <= ACTIVE_N_RST;
            sys_mgmt_pending  <= PEND_RST;
        end else begin
            state             <= next_state;
            sys_mgmt_take     <= next_take;
            ext_irq_take      <= next_irq_take;
            sys_mgmt_mode     <= next_mode;
            sys_mgmt_active_n <= next_active_n;
            sys_mgmt_pending  <= next_sys_mgmt_pending;
        end
    end

    // request captured on a falling pin edge
    property p_latch;
        @(posedge clk_sys) disable iff (sys_rst)
        fall |=> pend && sys_mgmt_pending;
    endproperty
    a_latch: assert property (p_latch) else $error("edge not latched");

    // management grant leaves every ordinary grant idle
    property p_prio;
        @(posedge clk_sys) disable iff (sys_rst)
        take |=> sys_mgmt_take && ext_irq_take == '0;
    endproperty
    a_prio: assert property (p_prio) else $error("ordinary irq beat mgmt");

    property p_boundary;
        @(posedge clk_sys) disable iff (sys_rst)
        !(instr_boundary || rep_iter_boundary) |=> !sys_mgmt_take;
    endproperty
    a_boundary: assert property (p_boundary) else $error("take off boundary");

    property p_sample;
        @(posedge clk_sys) disable iff (sys_rst)
        rep_iter_boundary && pend && !bus_locked && state == ST_NORMAL |=> sys_mgmt_take;
    endproperty
    a_sample: assert property (p_sample) else $error("string step missed");

    property p_lock;
        @(posedge clk_sys) disable iff (sys_rst)
        bus_locked || state != ST_NORMAL |=> !sys_mgmt_take;
    endproperty
    a_lock: assert property (p_lock) else $error("entry while locked or in mode");

    property p_hold2;
        @(posedge clk_sys) disable iff (sys_rst)
        state == ST_IN_MODE && fall |=> pend;
    endproperty
    a_hold2: assert property (p_hold2) else $error("second request dropped");

    sequence s_resume;
        state == ST_IN_MODE && mode_resume_instr;
    endsequence
    property p_resume;
        @(posedge clk_sys) disable iff (sys_rst)
        s_resume |=> !sys_mgmt_take && !sys_mgmt_mode && sys_mgmt_active_n;
    endproperty
    a_resume: assert property (p_resume) else $error("bad resume exit");

    property p_active;
        @(posedge clk_sys) disable iff (sys_rst)
        take |=> !sys_mgmt_active_n && sys_mgmt_mode;
    endproperty
    a_active: assert property (p_active) else $error("active not low at entry");

    property p_reset;
        @(posedge clk_sys)
        sys_rst |=> sys_mgmt_active_n && !pend && !sys_mgmt_mode;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");

    property p_clear;
        @(posedge clk_sys) disable iff (sys_rst)
        take && !fall |=> !pend;
    endproperty
    a_clear: assert property (p_clear) else $error("pending not cleared");

    // a grant is one cycle wide; the mode state refuses the next one
    property p_take_pulse;
        @(posedge clk_sys) disable iff (sys_rst)
        sys_mgmt_take |=> !sys_mgmt_take;
    endproperty
    a_take_pulse: assert property (p_take_pulse) else $error("grant too long");

    // entry already counts as mode: active pin low from its first cycle
    sequence s_entry_busy;
        state == ST_ENTRY;
    endsequence
    property p_entry_low;
        @(posedge clk_sys) disable iff (sys_rst)
        s_entry_busy |=> !sys_mgmt_active_n && sys_mgmt_mode;
    endproperty
    a_entry_low: assert property (p_entry_low) else $error("active high in entry");

    sequence s_mode_busy;
        state == ST_IN_MODE && !mode_resume_instr;
    endsequence
    property p_mode_low;
        @(posedge clk_sys) disable iff (sys_rst)
        s_mode_busy |=> !sys_mgmt_active_n && sys_mgmt_mode;
    endproperty
    a_mode_low: assert property (p_mode_low) else $error("mode left without resume");

    // a refused request must survive until a recognition point accepts it
    sequence s_waiting;
        pend && !take;
    endsequence
    property p_wait;
        @(posedge clk_sys) disable iff (sys_rst)
        s_waiting |=> pend;
    endproperty
    a_wait: assert property (p_wait) else $error("waiting request lost");

    // visible pending flag tracks the latch without a cycle of lag
    property p_pend_out;
        @(posedge clk_sys) disable iff (sys_rst)
        sys_mgmt_pending == pend;
    endproperty
    a_pend_out: assert property (p_pend_out) else $error("pending flag out of step");

    // at most one ordinary grant, never beside a management grant
    property p_one_grant;
        @(posedge clk_sys) disable iff (sys_rst)
        $onehot0(ext_irq_take) && !(sys_mgmt_take && ext_irq_take != '0);
    endproperty
    a_one_grant: assert property (p_one_grant) else $error("grants overlap");
endmodule
`default_nettype wire

// file: sim/smi_source.sv
// request source model driving the active-low management pin
`timescale 1ns/100ps
`default_nettype none
module smi_source (
    // clock
    input  wire logic clk_sys,
    // trigger from bench
    input  wire logic fire,
    // request pin, driven high when idle
    output logic      req_n
);
    int   cnt = 0;
    logic f;
    logic hold_low = 1'b0;
    // low for two cycles then released; the model drives it high again
    assign req_n = ~hold_low;
    always @(posedge clk_sys) begin
        f = fire;
        #1;
        if (f)
            cnt = 2;
        hold_low = (cnt != 0);
        if (cnt > 0)
            cnt--;
    end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// self-checking bench for the management interrupt entry block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic       clk_sys = 0, sys_rst = 1, fire = 0, sys_mgmt_req_n;
    logic       instr_boundary = 0, rep_iter_boundary = 0, bus_locked = 0;
    logic       entry_done = 0, mode_resume_instr = 0;
    logic [7:0] ext_irq_req = 8'h00, ext_irq_take, seen_ext;
    logic       sys_mgmt_take, sys_mgmt_mode, sys_mgmt_active_n, sys_mgmt_pending, seen;
    int         n_mismatch = 0, compares = 0;
    initial forever #2 clk_sys = ~clk_sys;
    smi_source i_smi_source (.clk_sys(clk_sys), .fire(fire), .req_n(sys_mgmt_req_n));
    system_mgmt_irq_entry i_system_mgmt_irq_entry (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .sys_mgmt_req_n(sys_mgmt_req_n), .ext_irq_req(ext_irq_req),
        .instr_boundary(instr_boundary), .rep_iter_boundary(rep_iter_boundary),
        .bus_locked(bus_locked), .entry_done(entry_done),
        .mode_resume_instr(mode_resume_instr), .sys_mgmt_take(sys_mgmt_take),
        .ext_irq_take(ext_irq_take), .sys_mgmt_mode(sys_mgmt_mode),
        .sys_mgmt_active_n(sys_mgmt_active_n), .sys_mgmt_pending(sys_mgmt_pending));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys) #1;
    endtask
    // one strobe: 0 fire, 1 instr, 2 rep, 3 entry done, 4 resume
    task automatic drive(input int k, input logic v);
        case (k)
            0: fire = v;
            1: instr_boundary = v;
            2: rep_iter_boundary = v;
            3: entry_done = v;
            default: mode_resume_instr = v;
        endcase
    endtask
    // one-cycle pulse; only the pulsed strobe is lowered again
    task automatic pulse(input int k);
        drive(k, 1'b1);
        step(1);
        drive(k, 1'b0);
        if (k == 0)
            step(2);
    endtask
    // bounded look for grant pulses after a boundary
    task automatic grant(input int k, input logic exp);
        pulse(k);
        seen = 0;
        seen_ext = 8'h00;
        repeat (3) begin
            seen = seen | sys_mgmt_take;
            seen_ext = seen_ext | ext_irq_take;
            step(1);
        end
        chk(seen, exp);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic t_basic;
        ext_irq_req = 8'h0C;
        pulse(0);
        chk(sys_mgmt_pending, 1);
        grant(1, 1);
        chk(seen_ext, 8'h00);
        chk(sys_mgmt_pending, 0);
        pulse(3);
        chk(sys_mgmt_active_n, 0);
        chk(sys_mgmt_mode, 1);
        pulse(4);
        step(1);
        chk(sys_mgmt_active_n, 1);
        chk(sys_mgmt_mode, 0);
        grant(1, 0);
        chk(seen_ext, 8'h04);
        ext_irq_req = 8'h00;
        $display("test basic done");
    endtask
    task automatic t_mode;
        pulse(0);
        bus_locked = 1;
        grant(2, 0);
        bus_locked = 0;
        grant(2, 1);
        pulse(3);
        pulse(0);
        chk(sys_mgmt_pending, 1);
        grant(1, 0);
        chk(sys_mgmt_pending, 1);
        pulse(4);
        grant(1, 1);
        pulse(3);
        pulse(0);
        sys_rst = 1;
        step(2);
        chk({sys_mgmt_active_n, sys_mgmt_mode, sys_mgmt_pending}, 3'h4);
        sys_rst = 0;
        grant(1, 0);
        $display("test mode done");
    endtask
    initial begin
        step(2);
        sys_rst = 0;
        t_basic();
        t_mode();
        conclude();
    end
endmodule
`default_nettype wire
